// File: logic/uie_pkg.sv
package uie_pkg;
  // Register offsets on the three address lines
  localparam logic [2:0] ADDR_DATA     = 3'h0;
  localparam logic [2:0] ADDR_IMASK    = 3'h1;
  localparam logic [2:0] ADDR_CAUSE    = 3'h2;
  localparam logic [2:0] ADDR_LFMT     = 3'h3;
  localparam logic [2:0] ADDR_LCOND    = 3'h5;
  localparam logic [2:0] ADDR_MCOND    = 3'h6;
  localparam logic [2:0] ADDR_SEVEN    = 3'h7;
  localparam logic [2:0] ADDR_FLOW_LO  = 3'h4;
  // Key in line format control that opens the enhanced map
  localparam logic [7:0] ENH_KEY       = 8'hBF;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  // Field positions
  localparam int IM_RX        = 0;
  localparam int IM_TX        = 1;
  localparam int IM_LS        = 2;
  localparam int IM_MS        = 3;
  localparam int QC_EN        = 0;
  localparam int QC_RXRST     = 1;
  localparam int QC_TXRST     = 2;
  localparam int QC_TXTRIG_LO = 4;
  localparam int QC_RXTRIG_LO = 6;
  localparam int EFC_ENH      = 4;
  localparam int FC_TRG_RX    = 7;
  localparam int FC_EMC_SEL   = 6;
  localparam int FC_TBL_LO    = 4;
  localparam int EMC_IMD      = 6;
  localparam int EMC_CNT_TX   = 0;
  localparam int LFMT_DIV     = 7;
  localparam logic [1:0] TBL_PROG = 2'h3;
  // Interrupt cause codes, bits 5..0
  localparam logic [5:0] CAUSE_LS   = 6'h06;
  localparam logic [5:0] CAUSE_TO   = 6'h0C;
  localparam logic [5:0] CAUSE_RX   = 6'h04;
  localparam logic [5:0] CAUSE_TX   = 6'h02;
  localparam logic [5:0] CAUSE_MS   = 6'h00;
  localparam logic [5:0] CAUSE_NONE = 6'h01;
  // Fixed trigger table, one entry per two-bit select
  localparam int FILL_W = 7;
  localparam logic [6:0] TRIG_0 = 7'h01;
  localparam logic [6:0] TRIG_1 = 7'h04;
  localparam logic [6:0] TRIG_2 = 7'h08;
  localparam logic [6:0] TRIG_3 = 7'h0E;

  typedef struct packed {
    logic [6:0] rx_fill;
    logic [6:0] tx_fill;
    logic       tx_shifter_empty;
    logic       rx_head_valid;
    logic [2:0] rx_head_err;
    logic       rx_push;
    logic [2:0] rx_push_err;
    logic       rx_overrun;
    logic       rx_timeout;
    logic       rx_err_any;
    logic       modem_delta_any;
  } uie_fifo_stat_t;
endpackage

// File: logic/uie_channel_irq.sv
`timescale 1ns/1ps
// Behaviour
// - Interrupt mask gates rx data, tx empty, line and modem interrupts into cause.
// - FIFO mode: rx data interrupt while fill at or above trigger level.
// - Cause indication drops when fill falls below trigger; interrupt output drops one cycle later.
// - Receive ready status set on first character in FIFO, cleared when empty.
// - FIFO on with mask bits 0-3 clear gives polled mode, no interrupt.
// - Line condition holds separate receive and transmit status bits.
// - Line condition bit 1 set on receive overrun.
// - Bits 2-4 give parity, framing, break of character at holding output.
// - Bit 5 set while transmit holding register or FIFO is empty.
// - Bit 6 set only while transmit FIFO and shifter are both empty.
// - Bit 7 set in FIFO mode while any character in receive FIFO has an error.
// - Mask bit 0 enables rx ready: character held, or trigger reached.
// - Mask bit 1 enables tx ready: holding empty, or fill below trigger.
// - Enabling tx ready while already empty raises it at once.
// - Mask bit 2 enables line interrupt on line condition bits 1 to 4.
// - Overrun raises line interrupt at once on reception.
// - Error bits interrupt at readout, or on reception when extended bit 6 set.
// - Mask bit 3 gates the modem interrupt, reset value disabled.
// - Cause read returns highest pending source; others stay queued.
// - Line condition read clears line interrupt, modem read clears modem interrupt.
// - Holding read clears time-out; cause read showing tx ready, or holding write, clears tx ready.
module uie_channel_irq #(
  parameter int         FIFO_DEPTH = 64,
  parameter logic [7:0] DEVICE_ID  = 8'h5C  // Arbitrary identity value
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    bus_cs_i,
  input  wire logic [2:0]              bus_addr_i,
  input  wire logic                    bus_rd_i,
  input  wire logic                    bus_wr_i,
  input  wire logic [7:0]              bus_wdata_i,
  output logic      [7:0]              bus_rdata_o,
  input  wire uie_pkg::uie_fifo_stat_t fifo_stat_i,
  input  wire logic [7:0]              rx_data_i,
  input  wire logic [7:0]              modem_condition_i,
  input  wire logic                    divisor_zero_i,
  output logic                         rx_pop_o,
  output logic                         tx_push_o,
  output logic      [7:0]              tx_data_o,
  output logic                         rx_fifo_reset_o,
  output logic                         tx_fifo_reset_o,
  output logic                         fifo_enable_o,
  output logic                         irq_o
);

  if (FIFO_DEPTH < 1 || FIFO_DEPTH > 127) begin : g_depth_check
    $error("FIFO_DEPTH does not fit the fill count width");
  end

  function automatic logic [6:0] trig_lookup(input logic [1:0] sel);
    logic [6:0] t;
    t = uie_pkg::TRIG_0;
    unique case (sel)
      2'h0: t = uie_pkg::TRIG_0;
      2'h1: t = uie_pkg::TRIG_1;
      2'h2: t = uie_pkg::TRIG_2;
      2'h3: t = uie_pkg::TRIG_3;
    endcase
    return t;
  endfunction

  logic [7:0] imask_reg;
  logic [7:0] lfmt_reg;
  logic       qc_en_reg;
  logic [1:0] rx_sel_reg;
  logic [1:0] tx_sel_reg;
  logic [7:0] efc_reg;
  logic [7:0] feature_control_reg;
  logic [7:0] emc_reg;
  logic [7:0] scratch_reg;
  logic [7:0] rx_trg_reg;
  logic [7:0] tx_trg_reg;
  logic [7:0] flow_chars_reg [4];
  logic       tx_arm_reg, tx_int_reg, ls_int_reg, overrun_reg, to_int_reg, ms_int_reg;
  logic       delta_seen_reg, head_err_seen_reg, irq_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  logic       enh, norm, wr, rd;
  logic [6:0] rx_trig, tx_trig;
  logic       rx_cond, tx_cond, tx_arm, head_err_now, err_event;
  logic       p_ls, p_to, p_rx, p_tx, p_ms;
  logic [5:0] cause;
  logic [7:0] lcond;
  logic       rd_cause, rd_lcond, rd_mcond, rd_hold, wr_hold, wr_qc;

  // Address decode
  assign enh      = (lfmt_reg == uie_pkg::ENH_KEY);
  assign norm     = ~lfmt_reg[uie_pkg::LFMT_DIV];
  assign wr       = bus_cs_i & bus_wr_i;
  assign rd       = bus_cs_i & bus_rd_i;
  assign rd_cause = rd & ~enh & (bus_addr_i == uie_pkg::ADDR_CAUSE);
  assign rd_lcond = rd & ~enh & (bus_addr_i == uie_pkg::ADDR_LCOND);
  assign rd_mcond = rd & ~enh & (bus_addr_i == uie_pkg::ADDR_MCOND);
  assign rd_hold  = rd & norm & (bus_addr_i == uie_pkg::ADDR_DATA);
  assign wr_hold  = wr & norm & (bus_addr_i == uie_pkg::ADDR_DATA);
  assign wr_qc    = wr & ~enh & (bus_addr_i == uie_pkg::ADDR_CAUSE);

  // Trigger levels, fixed table or programmed value
  always_comb begin
    if (feature_control_reg[uie_pkg::FC_TBL_LO +: 2] == uie_pkg::TBL_PROG) begin
      rx_trig = rx_trg_reg[6:0];
      tx_trig = tx_trg_reg[6:0];
    end else begin
      rx_trig = trig_lookup(rx_sel_reg);
      tx_trig = trig_lookup(tx_sel_reg);
    end
  end

  assign rx_cond = qc_en_reg ? (fifo_stat_i.rx_fill >= rx_trig) : (fifo_stat_i.rx_fill != 7'h00);
  assign tx_cond = qc_en_reg ? (fifo_stat_i.tx_fill < tx_trig) : (fifo_stat_i.tx_fill == 7'h00);
  assign tx_arm  = tx_cond & imask_reg[uie_pkg::IM_TX];

  assign head_err_now = fifo_stat_i.rx_head_valid & (|fifo_stat_i.rx_head_err);
  assign err_event = emc_reg[uie_pkg::EMC_IMD] ? (fifo_stat_i.rx_push & (|fifo_stat_i.rx_push_err))
                                               : (head_err_now & ~head_err_seen_reg);

  // mask gating; rx source follows the level
  assign p_ls = imask_reg[uie_pkg::IM_LS] & ls_int_reg;
  assign p_to = imask_reg[uie_pkg::IM_RX] & to_int_reg;
  assign p_rx = imask_reg[uie_pkg::IM_RX] & rx_cond;
  assign p_tx = imask_reg[uie_pkg::IM_TX] & tx_int_reg;
  assign p_ms = imask_reg[uie_pkg::IM_MS] & ms_int_reg;

  always_comb begin
    if (p_ls) begin
      cause = uie_pkg::CAUSE_LS;
    end else if (p_to) begin
      cause = uie_pkg::CAUSE_TO;
    end else if (p_rx) begin
      cause = uie_pkg::CAUSE_RX;
    end else if (p_tx) begin
      cause = uie_pkg::CAUSE_TX;
    end else if (p_ms) begin
      cause = uie_pkg::CAUSE_MS;
    end else begin
      cause = uie_pkg::CAUSE_NONE;
    end
  end

  assign lcond = {qc_en_reg & fifo_stat_i.rx_err_any,
                  (fifo_stat_i.tx_fill == 7'h00) & fifo_stat_i.tx_shifter_empty,
                  (fifo_stat_i.tx_fill == 7'h00),
                  fifo_stat_i.rx_head_valid & fifo_stat_i.rx_head_err[2],
                  fifo_stat_i.rx_head_valid & fifo_stat_i.rx_head_err[1],
                  fifo_stat_i.rx_head_valid & fifo_stat_i.rx_head_err[0],
                  overrun_reg,
                  (fifo_stat_i.rx_fill != 7'h00)};

  // Control registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      imask_reg   <= uie_pkg::RST_BYTE;
      lfmt_reg    <= uie_pkg::RST_BYTE;
      efc_reg     <= uie_pkg::RST_BYTE;
      feature_control_reg    <= uie_pkg::RST_BYTE;
      emc_reg     <= uie_pkg::RST_BYTE;
      scratch_reg <= uie_pkg::RST_BYTE;
      rx_trg_reg  <= uie_pkg::RST_BYTE;
      tx_trg_reg  <= uie_pkg::RST_BYTE;
      for (int i = 0; i < 4; i++) begin
        flow_chars_reg[i] <= uie_pkg::RST_BYTE;
      end
    end else if (wr) begin
      if (bus_addr_i == uie_pkg::ADDR_LFMT) begin
        lfmt_reg <= bus_wdata_i;
      end
      if (enh) begin
        unique case (bus_addr_i)
          uie_pkg::ADDR_DATA: begin
            if (feature_control_reg[uie_pkg::FC_TRG_RX]) begin
              rx_trg_reg <= bus_wdata_i;
            end else begin
              tx_trg_reg <= bus_wdata_i;
            end
          end
          uie_pkg::ADDR_IMASK: feature_control_reg <= bus_wdata_i;
          uie_pkg::ADDR_CAUSE: efc_reg  <= bus_wdata_i;
          3'h4, 3'h5, 3'h6, 3'h7: flow_chars_reg[bus_addr_i[1:0]] <= bus_wdata_i;
          default: ;
        endcase
      end else if (bus_addr_i == uie_pkg::ADDR_IMASK && norm) begin
        // Upper enables only with enhanced access on
        imask_reg <= efc_reg[uie_pkg::EFC_ENH] ? bus_wdata_i : {4'h0, bus_wdata_i[3:0]};
      end else if (bus_addr_i == uie_pkg::ADDR_SEVEN) begin
        if (feature_control_reg[uie_pkg::FC_EMC_SEL]) begin
          emc_reg <= bus_wdata_i;
        end else begin
          scratch_reg <= bus_wdata_i;
        end
      end
    end
  end

  // Queue control; other fields only take with the enable bit set
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      qc_en_reg       <= 1'b0;
      rx_sel_reg      <= 2'h0;
      tx_sel_reg      <= 2'h0;
      rx_fifo_reset_o <= 1'b0;
      tx_fifo_reset_o <= 1'b0;
    end else begin
      rx_fifo_reset_o <= wr_qc & bus_wdata_i[uie_pkg::QC_EN] & bus_wdata_i[uie_pkg::QC_RXRST];
      tx_fifo_reset_o <= wr_qc & bus_wdata_i[uie_pkg::QC_EN] & bus_wdata_i[uie_pkg::QC_TXRST];
      if (wr_qc) begin
        qc_en_reg <= bus_wdata_i[uie_pkg::QC_EN];
        if (bus_wdata_i[uie_pkg::QC_EN]) begin
          rx_sel_reg <= bus_wdata_i[uie_pkg::QC_RXTRIG_LO +: 2];
          if (efc_reg[uie_pkg::EFC_ENH]) begin
            tx_sel_reg <= bus_wdata_i[uie_pkg::QC_TXTRIG_LO +: 2];
          end
        end
      end
    end
  end

  // Interrupt sources; set wins over clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_arm_reg        <= 1'b0;
      tx_int_reg        <= 1'b0;
      ls_int_reg        <= 1'b0;
      overrun_reg       <= 1'b0;
      to_int_reg        <= 1'b0;
      ms_int_reg        <= 1'b0;
      delta_seen_reg    <= 1'b0;
      head_err_seen_reg <= 1'b0;
    end else begin
      tx_arm_reg        <= tx_arm;
      delta_seen_reg    <= fifo_stat_i.modem_delta_any;
      head_err_seen_reg <= head_err_now;
      if (tx_arm & ~tx_arm_reg) begin
        tx_int_reg <= 1'b1;
      end else if (wr_hold || (rd_cause && cause == uie_pkg::CAUSE_TX)) begin
        tx_int_reg <= 1'b0;
      end
      if (fifo_stat_i.rx_overrun) begin
        overrun_reg <= 1'b1;
      end else if (rd_lcond) begin
        overrun_reg <= 1'b0;
      end
      if (fifo_stat_i.rx_overrun | err_event) begin
        ls_int_reg <= 1'b1;
      end else if (rd_lcond) begin
        ls_int_reg <= 1'b0;
      end
      if (qc_en_reg & fifo_stat_i.rx_timeout) begin
        to_int_reg <= 1'b1;
      end else if (rd_hold) begin
        to_int_reg <= 1'b0;
      end
      if (fifo_stat_i.modem_delta_any & ~delta_seen_reg) begin
        ms_int_reg <= 1'b1;
      end else if (rd_mcond) begin
        ms_int_reg <= 1'b0;
      end
    end
  end

  // Read data select
  always_comb begin
    rdata_next = 8'h00;
    if (bus_addr_i == uie_pkg::ADDR_LFMT) begin
      rdata_next = lfmt_reg;
    end else if (enh) begin
      unique case (bus_addr_i)
        uie_pkg::ADDR_DATA:  rdata_next = {1'b0, emc_reg[uie_pkg::EMC_CNT_TX] ? fifo_stat_i.tx_fill
                                                                               : fifo_stat_i.rx_fill};
        uie_pkg::ADDR_IMASK: rdata_next = feature_control_reg;
        uie_pkg::ADDR_CAUSE: rdata_next = efc_reg;
        3'h4, 3'h5, 3'h6, 3'h7: rdata_next = flow_chars_reg[bus_addr_i[1:0]];
        default: rdata_next = 8'h00;
      endcase
    end else begin
      unique case (bus_addr_i)
        uie_pkg::ADDR_DATA:  rdata_next = norm ? rx_data_i : 8'h00;
        uie_pkg::ADDR_IMASK: rdata_next = norm ? imask_reg : (divisor_zero_i ? DEVICE_ID : 8'h00);
        uie_pkg::ADDR_CAUSE: rdata_next = {qc_en_reg, qc_en_reg, cause};
        uie_pkg::ADDR_LCOND: rdata_next = lcond;
        uie_pkg::ADDR_MCOND: rdata_next = modem_condition_i;
        uie_pkg::ADDR_SEVEN: rdata_next = feature_control_reg[uie_pkg::FC_EMC_SEL] ? {1'b0, qc_en_reg ? fifo_stat_i.rx_fill
                                                                                          : 7'h00}
                                                                        : scratch_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Bus answer and strobes to the FIFOs
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= 8'h00;
      rx_pop_o  <= 1'b0;
      tx_push_o <= 1'b0;
      tx_data_o <= 8'h00;
    end else begin
      rx_pop_o  <= rd_hold;
      tx_push_o <= wr_hold;
      if (rd) begin
        rdata_reg <= rdata_next;
      end
      if (wr_hold) begin
        tx_data_o <= bus_wdata_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= p_ls | p_to | p_rx | p_tx | p_ms;
    end
  end

  assign bus_rdata_o   = rdata_reg;
  assign irq_o         = irq_reg;
  assign fifo_enable_o = qc_en_reg;

endmodule

// File: verif/uie_channel_irq_monitor.sv
`timescale 1ns/1ps
module uie_channel_irq_monitor (
  input wire logic                    sys_clk_i,
  input wire logic                    rst_i,
  input wire logic                    bus_cs_i,
  input wire logic [2:0]              bus_addr_i,
  input wire logic                    bus_rd_i,
  input wire logic                    bus_wr_i,
  input wire logic [7:0]              bus_wdata_i,
  input wire logic [7:0]              bus_rdata_o,
  input wire uie_pkg::uie_fifo_stat_t fifo_stat_i,
  input wire logic                    rx_pop_o,
  input wire logic                    tx_push_o,
  input wire logic [7:0]              tx_data_o,
  input wire logic                    fifo_enable_o,
  input wire logic                    irq_o
);
  logic [7:0] lfmt_reg;
  logic [3:0] mask_reg;
  logic       nrm;
  assign nrm = !lfmt_reg[7];
  // Shadow of line format, selects the normal map
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) lfmt_reg <= 8'h00;
    else if (bus_cs_i && bus_wr_i && bus_addr_i == 3'h3) lfmt_reg <= bus_wdata_i;
  end
  // Shadow of the four low mask bits
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) mask_reg <= 4'h0;
    else if (bus_cs_i && bus_wr_i && bus_addr_i == 3'h1 && nrm) mask_reg <= bus_wdata_i[3:0];
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence line_rd;
    bus_cs_i && bus_rd_i && bus_addr_i == 3'h5 && nrm;
  endsequence
  chk_rx_pop: assert property (
    rx_pop_o == $past(bus_cs_i && bus_rd_i && bus_addr_i == 3'h0 && nrm)) else $error("pop mismatch");
  chk_tx_push: assert property (
    bus_cs_i && bus_wr_i && bus_addr_i == 3'h0 && nrm |=> tx_push_o && tx_data_o == $past(bus_wdata_i))
    else $error("holding write lost");
  chk_poll_quiet: assert property (
    fifo_enable_o && mask_reg == 4'h0 |=> !irq_o) else $error("irq in polled mode");
  chk_rx_level: assert property (
    !fifo_enable_o && mask_reg[0] && fifo_stat_i.rx_fill != 7'h00 |=> irq_o) else $error("rx irq missing");
  chk_ready_bit: assert property (
    line_rd |=> bus_rdata_o[0] == ($past(fifo_stat_i.rx_fill) != 7'h00)) else $error("ready bit wrong");
  chk_thr_empty: assert property (
    line_rd |=> bus_rdata_o[5] == ($past(fifo_stat_i.tx_fill) == 7'h00)) else $error("holding empty bit wrong");
  chk_tx_idle: assert property (
    line_rd |=> bus_rdata_o[6] == ($past(fifo_stat_i.tx_fill) == 7'h00 && $past(fifo_stat_i.tx_shifter_empty)))
    else $error("tx idle bit wrong");
  chk_overrun_bit: assert property (
    fifo_stat_i.rx_overrun ##1 !(bus_cs_i && bus_rd_i && bus_addr_i == 3'h5) ##1 line_rd |=> bus_rdata_o[1])
    else $error("overrun bit missing");
  chk_overrun_irq: assert property (
    mask_reg[2] && fifo_stat_i.rx_overrun |=> ##[0:1] irq_o) else $error("overrun irq late");
  chk_cause_idle: assert property (
    bus_cs_i && bus_rd_i && bus_addr_i == 3'h2 && nrm && mask_reg == 4'h0 |=> bus_rdata_o[5:0] == 6'h01)
    else $error("masked cause shown");
  cover property (fifo_enable_o && $rose(irq_o));
  cover property (fifo_stat_i.rx_overrun ##2 line_rd);
  cover property (tx_push_o);
endmodule
bind uie_channel_irq uie_channel_irq_monitor u_mon (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_cs_i(bus_cs_i),
  .bus_addr_i(bus_addr_i), .bus_rd_i(bus_rd_i), .bus_wr_i(bus_wr_i), .bus_wdata_i(bus_wdata_i),
  .bus_rdata_o(bus_rdata_o), .fifo_stat_i(fifo_stat_i), .rx_pop_o(rx_pop_o), .tx_push_o(tx_push_o),
  .tx_data_o(tx_data_o), .fifo_enable_o(fifo_enable_o), .irq_o(irq_o));

// File: verif/uie_fifo_model.sv
`timescale 1ns/1ps
module uie_fifo_model (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic              rx_in_i,
  input  wire logic [2:0]        rx_in_err_i,
  input  wire logic              tx_drain_i,
  input  wire logic              overrun_i,
  input  wire logic              modem_i,
  input  wire logic              timeout_i,
  input  wire logic              rx_pop_i,
  input  wire logic              tx_push_i,
  output uie_pkg::uie_fifo_stat_t stat_o
);
  logic [2:0] mem [0:127];
  logic [6:0] wp, rp, rx_cnt, tx_cnt, err_cnt;
  logic       busy;
  logic       pop;
  assign pop = rx_pop_i && rx_cnt != 7'h00;
  // Error flags of queued characters
  always_ff @(posedge sys_clk_i) begin
    if (rx_in_i) mem[wp] <= rx_in_err_i;
  end
  // Receive and transmit occupancy, shifter busy after last drain
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {wp, rp, rx_cnt, tx_cnt, err_cnt} <= 35'h0;
      busy <= 1'b0;
    end else begin
      wp <= wp + 7'(rx_in_i);
      rp <= rp + 7'(pop);
      rx_cnt <= rx_cnt + 7'(rx_in_i) - 7'(pop);
      err_cnt <= err_cnt + 7'(rx_in_i && rx_in_err_i != 3'h0) - 7'(pop && mem[rp] != 3'h0);
      tx_cnt <= tx_cnt + 7'(tx_push_i) - 7'(tx_drain_i && tx_cnt != 7'h00);
      if (tx_drain_i) busy <= tx_cnt != 7'h00;
    end
  end
  assign stat_o = '{rx_cnt, tx_cnt, !busy, rx_cnt != 7'h00, (rx_cnt != 7'h00) ? mem[rp] : 3'h0,
                    rx_in_i, rx_in_err_i, overrun_i, timeout_i, err_cnt != 7'h00, modem_i};
endmodule

// File: verif/test_uart_interrupt_enable_logic.sv
`timescale 1ns/1ps
module test_uart_interrupt_enable_logic;
  localparam logic [7:0] ID_VAL = 8'h5C; // Arbitrary identity value
  // Rows: write flag, offset, data or expected read value
  localparam logic [11:0] ROWS [20] = '{12'h100, 12'h201, 12'h560, 12'h69E, 12'h9F0, 12'h100, 12'h902,
    12'h202, 12'h201, 12'h900, 12'hBBF, 12'hA10, 12'h210, 12'hCA5, 12'h4A5, 12'hA00, 12'hB80, 12'h15C,
    12'hB00, 12'h400};
  logic                    sys_clk_i, rst_i, cs, rd, wr, rx_in, drain, ovr, mdm, pop, push, rxr, txr, fen, irq, tmo;
  logic [2:0]              addr, rx_err;
  logic [7:0]              wdata, rdata, tx_data, got;
  uie_pkg::uie_fifo_stat_t stat;
  int                      failures = 0;
  int                      comparisons = 0;
  uie_channel_irq #(.FIFO_DEPTH(64), .DEVICE_ID(ID_VAL)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .bus_cs_i(cs), .bus_addr_i(addr), .bus_rd_i(rd), .bus_wr_i(wr), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
    .fifo_stat_i(stat), .rx_data_i(8'h3C), .modem_condition_i(8'h9E), .divisor_zero_i(1'b1), .rx_pop_o(pop),
    .tx_push_o(push), .tx_data_o(tx_data), .rx_fifo_reset_o(rxr), .tx_fifo_reset_o(txr), .fifo_enable_o(fen),
    .irq_o(irq));
  uie_fifo_model PARTNER (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .rx_in_i(rx_in), .rx_in_err_i(rx_err),
    .tx_drain_i(drain), .overrun_i(ovr), .modem_i(mdm), .timeout_i(tmo), .rx_pop_i(pop), .tx_push_i(push),
    .stat_o(stat));
  task automatic final_report;
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected byte at %0t: %h, want %h", $time, g, e);
    end
  endtask
  task automatic cmp_flag(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected flag at %0t: %b, want %b", $time, g, e);
    end
  endtask
  // One register access, strobes held for one cycle
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    {cs, rd, wr} = {1'b1, !w, w};
    addr = a;
    wdata = d;
    @(negedge sys_clk_i);
    {cs, rd, wr} = 3'h0;
    got = rdata;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    cmp_byte(got, e);
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk_i);
    s = 1'b1;
    @(negedge sys_clk_i);
    s = 1'b0;
  endtask
  task automatic push_rx(input logic [2:0] e);
    rx_err = e;
    pulse(rx_in);
  endtask
  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 20) begin
      @(negedge sys_clk_i);
      n++;
    end
    cmp_flag(irq, e);
    if (irq !== e) final_report();
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    rst_i = 1'b1;
    {cs, rd, wr, rx_in, drain, ovr, mdm, tmo} = 8'h00;
    {addr, rx_err} = 6'h00;
    wdata = 8'h00;
    repeat (6) @(negedge sys_clk_i);
    rst_i = 1'b0;
    cmp_flag(irq, 1'b0);
    cmp_flag(fen, 1'b0);
    foreach (ROWS[i]) begin
      bus(ROWS[i][11], ROWS[i][10:8], ROWS[i][7:0]);
      if (!ROWS[i][11]) cmp_byte(got, ROWS[i][7:0]);
    end
    bus(1'b1, 3'h1, 8'h01);
    push_rx(3'h0);
    wait_irq(1'b1);
    rd_chk(3'h0, 8'h3C);
    wait_irq(1'b0);
    bus(1'b1, 3'h2, 8'h41);
    cmp_flag(fen, 1'b1);
    repeat (3) push_rx(3'h0);
    repeat (2) @(negedge sys_clk_i);
    cmp_flag(irq, 1'b0);
    rd_chk(3'h2, 8'hC1);
    rd_chk(3'h5, 8'h61);
    push_rx(3'h0);
    wait_irq(1'b1);
    rd_chk(3'h2, 8'hC4);
    rd_chk(3'h0, 8'h3C);
    wait_irq(1'b0);
    rd_chk(3'h2, 8'hC1);
    bus(1'b1, 3'h1, 8'h00);
    push_rx(3'h0);
    repeat (2) @(negedge sys_clk_i);
    cmp_flag(irq, 1'b0);
    rd_chk(3'h5, 8'h61);
    repeat (4) rd_chk(3'h0, 8'h3C);
    rd_chk(3'h5, 8'h60);
    bus(1'b1, 3'h1, 8'h04);
    pulse(ovr);
    rd_chk(3'h5, 8'h62);
    cmp_flag(irq, 1'b1);
    wait_irq(1'b0);
    rd_chk(3'h5, 8'h60);
    push_rx(3'h1);
    wait_irq(1'b1);
    rd_chk(3'h2, 8'hC6);
    rd_chk(3'h5, 8'hE5);
    wait_irq(1'b0);
    rd_chk(3'h0, 8'h3C);
    rd_chk(3'h5, 8'h60);
    bus(1'b1, 3'h3, 8'hBF);
    bus(1'b1, 3'h1, 8'h40);
    bus(1'b1, 3'h3, 8'h00);
    bus(1'b1, 3'h7, 8'h40);
    push_rx(3'h0);
    push_rx(3'h2);
    wait_irq(1'b1);
    rd_chk(3'h5, 8'hE1);
    repeat (2) rd_chk(3'h0, 8'h3C);
    rd_chk(3'h5, 8'h60);
    bus(1'b1, 3'h1, 8'h08);
    mdm = 1'b1;
    wait_irq(1'b1);
    rd_chk(3'h2, 8'hC0);
    rd_chk(3'h6, 8'h9E);
    wait_irq(1'b0);
    bus(1'b1, 3'h1, 8'h02);
    wait_irq(1'b1);
    rd_chk(3'h2, 8'hC2);
    bus(1'b1, 3'h0, 8'h55);
    cmp_byte(tx_data, 8'h55);
    rd_chk(3'h5, 8'h00);
    pulse(drain);
    rd_chk(3'h5, 8'h20);
    wait_irq(1'b1);
    pulse(drain);
    rd_chk(3'h5, 8'h60);
    rd_chk(3'h2, 8'hC2);
    rd_chk(3'h2, 8'hC1);
    // Queue control reset strobes, then receive time-out
    bus(1'b1, 3'h2, 8'h47);
    cmp_flag(rxr, 1'b1);
    cmp_flag(txr, 1'b1);
    bus(1'b1, 3'h1, 8'h01);
    pulse(tmo);
    wait_irq(1'b1);
    rd_chk(3'h2, 8'hCC);
    rd_chk(3'h0, 8'h3C);
    wait_irq(1'b0);
    // Reset in mid-run
    @(negedge sys_clk_i);
    rst_i = 1'b1;
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    cmp_flag(irq, 1'b0);
    cmp_flag(fen, 1'b0);
    rd_chk(3'h1, 8'h00);
    final_report();
  end
endmodule
